// *** rtl/acc_ctrl.sv ***
/*
 acc_ctrl: acquisition chain control, top module. Holds gain, offset,
 selector and enable settings, starts conversions and reports busy.
 assumes: software master on a byte strobe port; analog chain sits
 outside and takes its settings from ana_o.
*/
// Added by the designer: the plain strobed port and the placing of the registers.
//
// Contract
// - gain register bit 7 picks stage one gain, 0 unity, 1 ten.
// - gain register bits 6:0 hold stage three gain code in twelfths.
// - offset register bits 6:0 sign-magnitude stage three offset; bit 7 zero.
// - busy flag at select bit 7 reads 1 while converting.
// - busy may lag a start write by one sampling period.
// - default-load bit 6 reads 0, restores defaults.
// - default-load starts a fresh conversion, abandoning any running one.
// - selector bit 5 picks four differential pairs or seven common inputs.
// - selector bit 4 polarity, bits 3:1 channel.
// - select bit 0 picks reference pair one-zero or three-two.
// - four enable bits: converter, stage one, two, three.
// - stage two gain code 00..11 gives 1, 2, 5, 10.
// - stage two offset is sign-magnitude, bit 3 sign.
// - disabled stage is bypassed to the next stage.
// - start bit or default-load bit starts a conversion.
// - any chain register write resets the gain stages; code pulses stage_reset_o only for offsets 0 to 4, not control.
// - elementary conversion lasts osr plus one samples.
`timescale 1ns/1ps
module acc_ctrl
    import acc_pkg::*;
(
    input wire logic clk_i,              // system clock, 50 MHz
    input wire logic rst_i,              // async reset, active high
    input wire logic [3:0] addr_i,       // register address
    input wire logic [7:0] wdata_i,      // write data
    input wire logic wr_i,               // write strobe
    input wire logic rd_i,               // read strobe
    output logic [7:0] rdata_o,          // read data, cycle after rd_i
    output logic irq_o,                  // level interrupt
    output acc_analog_type ana_o,        // settings to the analog chain
    output logic [3:0] bypass_o,         // per-stage bypass, bit0 unused
    output logic stage_reset_o,          // one-cycle stage reset pulse
    output logic sample_tick_o           // sampling enable to converter
);
    // cfg1: enable[3:0], stage2 gain[5:4]; cfg2: speed, bias, nconv, osr
    logic [7:0] cfg1_r;
    logic [7:0] cfg2_r;
    logic [7:0] gain_r;
    logic [6:0] offs_r;
    logic [4:0] insel_r;
    logic ref_r;
    logic [3:0] s2off_r;
    logic [1:0] ctrl_r;   // start (pulse), continuous
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic go_r;
    logic busy;
    logic done;
    logic tick;
    logic busy_q;
    logic wr_chain;
    logic wr_def;
    logic wr_start;
    logic stat_rd;
    logic [15:0] osr;
    logic [3:0] nconv;
    logic [7:0] rd_nxt;

    assign wr_chain = wr_i && (addr_i <= ACC_OFS_SEL);
    assign wr_def = wr_i && addr_i == ACC_OFS_SEL && wdata_i[ACC_BIT_DEF];
    assign wr_start = wr_i && addr_i == ACC_OFS_CTRL
        && wdata_i[ACC_BIT_START];
    assign stat_rd = rd_i && addr_i == ACC_OFS_IRQ_STAT;
    // osr = 8 << code, elementary conversions = 1 << code
    assign osr = ACC_OSR_BASE << cfg2_r[2:0];
    assign nconv = 4'h1 << cfg2_r[4:3];

    // settings registers, cleared to zero at reset
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg1_r <= ACC_RST_BYTE;
            cfg2_r <= ACC_RST_BYTE;
            gain_r <= ACC_RST_BYTE;
            offs_r <= 7'h00;
            insel_r <= 5'h00;
            ref_r <= 1'b0;
            s2off_r <= 4'h0;
        end
        else if (wr_def)
        begin
            // defaults: stages off, max speed, nominal bias, 2 conv, osr 32
            cfg1_r <= {4'h0, ACC_DEF_ENABLE};
            cfg2_r <= {ACC_DEF_SPEED[0], ACC_DEF_BIAS,
                ACC_DEF_NELCONV, ACC_DEF_OSR};
            insel_r <= wdata_i[5:1];
            ref_r <= wdata_i[ACC_BIT_REF];
        end
        else if (wr_i)
        begin
            case (addr_i)
                ACC_OFS_CFG1: cfg1_r <= wdata_i;
                ACC_OFS_CFG2: cfg2_r <= wdata_i;
                ACC_OFS_GAIN: gain_r <= wdata_i;
                ACC_OFS_OFFS: offs_r <= wdata_i[6:0];
                ACC_OFS_SEL:
                begin
                    insel_r <= wdata_i[5:1];
                    ref_r <= wdata_i[ACC_BIT_REF];
                end
                ACC_OFS_CTRL: s2off_r <= wdata_i[7:4];
                default: ;
            endcase
        end
    end

    // start control; continuous restarts on each completion
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= 2'b00;
            go_r <= 1'b0;
        end
        else
        begin
            if (wr_i && addr_i == ACC_OFS_CTRL)
                ctrl_r[ACC_BIT_CONTINUOUS_CONVERT] <= wdata_i[ACC_BIT_CONTINUOUS_CONVERT];
            ctrl_r[ACC_BIT_START] <= wr_start;
            go_r <= wr_def || wr_start
                || (wr_i && addr_i == ACC_OFS_CTRL && wdata_i[ACC_BIT_CONTINUOUS_CONVERT]
                    && !busy)
                || (done && ctrl_r[ACC_BIT_CONTINUOUS_CONVERT]);
        end
    end

    acc_tick u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(1'b0),
        .tick_o(tick)
    );

    // busy appears at the next sample edge, at most one period late
    acc_seq u_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .go_i(go_r),
        .tick_i(tick),
        .osr_i(osr),
        .nconv_i(nconv),
        .busy_o(busy),
        .done_o(done)
    );

    // interrupt status: set wins over read-clear
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stat_r <= 2'b00;
            mask_r <= 2'b00;
            busy_q <= 1'b0;
        end
        else
        begin
            busy_q <= busy;
            stat_r <= (stat_rd ? 2'b00 : stat_r)
                | {busy && !busy_q, done};
            if (wr_i && addr_i == ACC_OFS_IRQ_MASK)
                mask_r <= wdata_i[1:0];
        end
    end

    // read mux
    always_comb
    begin
        case (addr_i)
            ACC_OFS_CFG1: rd_nxt = cfg1_r;
            ACC_OFS_CFG2: rd_nxt = cfg2_r;
            ACC_OFS_GAIN: rd_nxt = gain_r;
            ACC_OFS_OFFS: rd_nxt = {1'b0, offs_r};
            ACC_OFS_SEL: rd_nxt = {busy, 1'b0, insel_r, ref_r};
            ACC_OFS_CTRL: rd_nxt = {s2off_r, 2'b00, ctrl_r[ACC_BIT_CONTINUOUS_CONVERT],
                1'b0};
            ACC_OFS_IRQ_STAT: rd_nxt = {6'h00, stat_r};
            ACC_OFS_IRQ_MASK: rd_nxt = {6'h00, mask_r};
            default: rd_nxt = 8'h00;
        endcase
    end

    // outputs, all registered
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 8'h00;
            irq_o <= 1'b0;
            ana_o <= '0;
            bypass_o <= 4'h0;
            stage_reset_o <= 1'b0;
            sample_tick_o <= 1'b0;
        end
        else
        begin
            rdata_o <= rd_i ? rd_nxt : 8'h00;
            irq_o <= |(((stat_rd ? 2'b00 : stat_r)
                | {busy && !busy_q, done}) & mask_r);
            ana_o.enable <= cfg1_r[3:0];
            ana_o.stage1_gain <= gain_r[ACC_BIT_STAGE1];
            ana_o.stage2_gain <= cfg1_r[5:4];
            ana_o.stage2_offset <= s2off_r;
            ana_o.stage3_gain <= gain_r[6:0];
            ana_o.stage3_offset <= offs_r;
            ana_o.input_sel <= insel_r;
            ana_o.ref_sel <= ref_r;
            // disabled stage passes its input straight on
            bypass_o <= {~cfg1_r[3:1], 1'b0};
            stage_reset_o <= wr_chain;
            sample_tick_o <= tick;
        end
    end

    // two sampling periods of slack for the lag check
    localparam int ACC_FS_DIV_I = 2 * ACC_FS_DIV;

    a_busy_lag: assert property (@(posedge clk_i) disable iff (rst_i)
        go_r |-> ##[1:ACC_FS_DIV_I] busy)
        else $error("busy late after start");
    a_busy_rd: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_i && addr_i == ACC_OFS_SEL |=> rdata_o[ACC_BIT_BUSY] == $past(busy))
        else $error("busy bit misread");
    a_def_rd0: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_i && addr_i == ACC_OFS_SEL |=> !rdata_o[ACC_BIT_DEF])
        else $error("default bit reads one");
    a_def_load: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_def |=> cfg1_r[3:0] == ACC_DEF_ENABLE && osr == 16'h0020
            && nconv == 4'h2)
        else $error("defaults not loaded");
    a_def_go: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_def |=> go_r)
        else $error("default load did not restart");
    a_offs_top: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_i && addr_i == ACC_OFS_OFFS |=> !rdata_o[7])
        else $error("offset bit 7 not zero");
    a_stage_rst: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_chain |=> stage_reset_o)
        else $error("stage reset missing");
    a_bypass_map: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(cfg1_r[1]) == 1'b0 && !$past(rst_i) |-> bypass_o[1])
        else $error("stage one not bypassed");
    a_gain_out: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_i && addr_i == ACC_OFS_GAIN && !wr_def |=> ##1
            ana_o.stage1_gain == $past(wdata_i[7], 2))
        else $error("stage one gain wrong");
    a_start_go: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start |=> go_r)
        else $error("start ignored");

    c_start: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_start ##[1:200] busy);
    c_done: cover property (@(posedge clk_i) disable iff (rst_i) done);
    c_def_abort: cover property (@(posedge clk_i) disable iff (rst_i)
        busy && wr_def);
    c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
endmodule : acc_ctrl

// *** rtl/acc_pkg.sv ***
/*
 acc_pkg: register offsets, field positions, defaults and types for the
 acquisition chain control block.
 assumes: one 50 MHz clock, byte registers on a plain strobe port.
*/
package acc_pkg;

    localparam int ACC_AW = 4;
    localparam int ACC_DW = 8;

    // register offsets
    localparam logic [3:0] ACC_OFS_CFG1 = 4'h0;
    localparam logic [3:0] ACC_OFS_CFG2 = 4'h1;
    localparam logic [3:0] ACC_OFS_GAIN = 4'h2;
    localparam logic [3:0] ACC_OFS_OFFS = 4'h3;
    localparam logic [3:0] ACC_OFS_SEL = 4'h4;
    localparam logic [3:0] ACC_OFS_CTRL = 4'h5;
    localparam logic [3:0] ACC_OFS_IRQ_STAT = 4'h6;
    localparam logic [3:0] ACC_OFS_IRQ_MASK = 4'h7;

    // field positions
    localparam int ACC_BIT_STAGE1 = 7;
    localparam int ACC_BIT_SIGN3 = 6;
    localparam int ACC_BIT_BUSY = 7;
    localparam int ACC_BIT_DEF = 6;
    localparam int ACC_BIT_REF = 0;
    localparam int ACC_BIT_START = 0;
    localparam int ACC_BIT_CONTINUOUS_CONVERT = 1;
    localparam int ACC_BIT_IRQ_DONE = 0;
    localparam int ACC_BIT_IRQ_START = 1;

    // reset and default values
    localparam logic [7:0] ACC_RST_BYTE = 8'h00;
    localparam logic [3:0] ACC_DEF_ENABLE = 4'h0;
    localparam logic [1:0] ACC_DEF_NELCONV = 2'h1;  // code 1: two conversions
    localparam logic [2:0] ACC_DEF_OSR = 3'h2;      // code 2: ratio 32
    localparam logic [1:0] ACC_DEF_SPEED = 2'h0;    // code 0: max speed
    localparam logic [1:0] ACC_DEF_BIAS = 2'h0;     // code 0: nominal
    localparam logic [15:0] ACC_OSR_BASE = 16'h0008;
    localparam logic [7:0] ACC_TAIL_CYC = 8'h04;

    // sampling clock divider (system cycles per sample)
    localparam int ACC_CLK_MHZ = 50;
    localparam int ACC_FS_KHZ = 500;
    localparam int ACC_FS_DIV = (ACC_CLK_MHZ * 1000) / ACC_FS_KHZ;

    typedef struct packed {
        logic [ACC_AW-1:0] addr;
        logic [ACC_DW-1:0] wdata;
        logic wr;
        logic rd;
    } acc_bus_type;

    typedef struct packed {
        logic [3:0] enable;
        logic stage1_gain;
        logic [1:0] stage2_gain;
        logic [3:0] stage2_offset;
        logic [6:0] stage3_gain;
        logic [6:0] stage3_offset;
        logic [4:0] input_sel;
        logic ref_sel;
    } acc_analog_type;

endpackage : acc_pkg

// *** rtl/acc_tick.sv ***
/*
 acc_tick: divider giving a one-cycle enable at the sampling rate.
 assumes: restart re-phases the divider so a sample edge follows.
*/
`timescale 1ns/1ps
module acc_tick
    import acc_pkg::*;
#(
    parameter int DIV = ACC_FS_DIV
)
(
    input wire logic clk_i,     // system clock
    input wire logic rst_i,     // async reset
    input wire logic restart_i, // re-phase divider
    output logic tick_o         // one-cycle sample enable
);
    logic [15:0] cnt_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_r <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (restart_i || cnt_r == 16'(DIV - 1))
        begin
            cnt_r <= 16'h0000;
            tick_o <= !restart_i;
        end
        else
        begin
            cnt_r <= cnt_r + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule : acc_tick

// *** rtl/acc_seq.sv ***
/*
 acc_seq: conversion sequencer on the sampling enable: elementary
 conversions of (osr+1) samples, then a quantization tail.
 assumes: go_i one-cycle pulse; tick_i from the sampling divider.
*/
`timescale 1ns/1ps
module acc_seq
    import acc_pkg::*;
(
    input wire logic clk_i,           // system clock
    input wire logic rst_i,           // async reset
    input wire logic go_i,            // start, abandons running sequence
    input wire logic tick_i,          // sampling enable
    input wire logic [15:0] osr_i,    // oversampling ratio
    input wire logic [3:0] nconv_i,   // elementary conversions
    output logic busy_o,              // conversion running
    output logic done_o               // one-cycle end pulse
);
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_ARM = 2'b01,
        ACC_CONV = 2'b11,
        ACC_TAIL = 2'b10
    } acc_seq_type;

    acc_seq_type st_r;
    logic [15:0] smp_r;
    logic [3:0] conv_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r <= ACC_IDLE;
            smp_r <= 16'h0000;
            conv_r <= 4'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (go_i)
            begin
                st_r <= ACC_ARM;
                busy_o <= 1'b0;
            end
            else if (tick_i)
            begin
                case (st_r)
                    ACC_ARM:
                    begin
                        // busy rises on the first sample edge
                        st_r <= ACC_CONV;
                        busy_o <= 1'b1;
                        smp_r <= 16'h0000;
                        conv_r <= 4'h0;
                    end
                    ACC_CONV:
                    begin
                        if (smp_r == osr_i)
                        begin
                            smp_r <= 16'h0000;
                            if (conv_r == nconv_i - 4'h1)
                                st_r <= ACC_TAIL;
                            conv_r <= conv_r + 4'h1;
                        end
                        else
                            smp_r <= smp_r + 16'h0001;
                    end
                    ACC_TAIL:
                    begin
                        if (smp_r == 16'(ACC_TAIL_CYC))
                        begin
                            st_r <= ACC_IDLE;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                        end
                        else
                            smp_r <= smp_r + 16'h0001;
                    end
                    default:
                        st_r <= ACC_IDLE;
                endcase
            end
        end
    end
endmodule : acc_seq

// *** dv/acc_testbench.sv ***
/*
 testbench: self-checking bench for acc_ctrl, driving the byte register
 port directly and judging settings, busy, interrupt and bypass outputs.
 assumes: acc_pkg compiled first; one 50 MHz clock, async high reset.
*/
`timescale 1ns/1ps
module testbench;
    import acc_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq_o;
    acc_analog_type ana_o;
    logic [3:0] bypass_o;
    logic stage_reset_o;
    logic sample_tick_o;
    int miscompares = 0;
    int samples_checked = 0;
    int cycle_cnt = 0;
    logic [7:0] rv;
    int cyc;
    int pulses;
    logic [7:0] tbl [0:10];

    acc_ctrl dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .irq_o(irq_o),
        .ana_o(ana_o),
        .bypass_o(bypass_o),
        .stage_reset_o(stage_reset_o),
        .sample_tick_o(sample_tick_o)
    );

    always #10 clk_i = ~clk_i;

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // ceiling: four short runs, one default run and the old run's start
    always @(posedge clk_i)
    begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 40000)
        begin
            miscompares = miscompares + 1;
            print_verdict();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : reg_wr

    // data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : reg_rd

    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    // polls busy through the select register, counting clock cycles
    task automatic wait_busy(input logic lvl, input int lim, output int n);
        logic [7:0] d;
        n = 0;
        d = 8'h00;
        while (n < lim)
        begin
            reg_rd(ACC_OFS_SEL, d);
            n = n + 2;
            if (d[ACC_BIT_BUSY] === lvl)
                break;
        end
    endtask : wait_busy

    function automatic logic [7:0] in_range(input int v, lo, hi);
        return (v >= lo && v <= hi) ? 8'h01 : 8'h00;
    endfunction : in_range

    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 8; a++)
        begin
            reg_rd(a[3:0], rv);
            check(rv, 8'h00);
        end
        // all stages reset disabled, so all three are bypassed
        check({4'h0, bypass_o}, 8'h0e);
        // sampling enable: one pulse per divider period
        pulses = 0;
        repeat (2 * ACC_FS_DIV)
        begin
            @(posedge clk_i);
            #1;
            if (sample_tick_o === 1'b1)
                pulses = pulses + 1;
        end
        check(pulses[7:0], 8'h02);
        // unmapped place: write lost, reads zero
        reg_wr(4'h9, 8'hff);
        reg_rd(4'h9, rv);
        check(rv, 8'h00);
        // gain and offset, boundary codes
        tbl[0] = 8'h00; tbl[1] = 8'h01; tbl[2] = 8'h7f;
        tbl[3] = 8'h80; tbl[4] = 8'hff;
        for (int i = 0; i < 5; i++)
        begin
            reg_wr(ACC_OFS_GAIN, tbl[i]);
            reg_rd(ACC_OFS_GAIN, rv);
            check(rv, tbl[i]);
            check({7'h0, ana_o.stage1_gain}, {7'h0, tbl[i][7]});
            check({1'b0, ana_o.stage3_gain}, {1'b0, tbl[i][6:0]});
            reg_wr(ACC_OFS_OFFS, tbl[i]);
            reg_rd(ACC_OFS_OFFS, rv);
            check(rv, {1'b0, tbl[i][6:0]});
            check({1'b0, ana_o.stage3_offset}, {1'b0, tbl[i][6:0]});
        end
        // one stage reset pulse per chain write, none for the mask
        for (int k = 0; k < 2; k++)
        begin
            pulses = 0;
            reg_wr(k == 0 ? ACC_OFS_GAIN : ACC_OFS_IRQ_MASK, 8'h00);
            repeat (4)
            begin
                #1;
                if (stage_reset_o === 1'b1)
                    pulses = pulses + 1;
                @(posedge clk_i);
            end
            check(pulses[7:0], k == 0 ? 8'h01 : 8'h00);
        end
        // input and reference selectors, both modes and polarities
        tbl[0] = 8'h00; tbl[1] = 8'h3f; tbl[2] = 8'h21; tbl[3] = 8'h1e;
        for (int i = 0; i < 4; i++)
        begin
            reg_wr(ACC_OFS_SEL, tbl[i]);
            reg_rd(ACC_OFS_SEL, rv);
            check(rv, tbl[i]);
            check({3'h0, ana_o.input_sel}, {3'h0, tbl[i][5:1]});
            check({7'h0, ana_o.ref_sel}, {7'h0, tbl[i][0]});
        end
        // every enable pattern and its bypass
        for (int e = 0; e < 16; e++)
        begin
            reg_wr(ACC_OFS_CFG1, {4'h0, e[3:0]});
            settle();
            check({4'h0, ana_o.enable}, {4'h0, e[3:0]});
            check({4'h0, bypass_o}, {4'h0, ~e[3:1], 1'b0});
        end
        for (int g = 0; g < 4; g++)
        begin
            reg_wr(ACC_OFS_CFG1, {2'b00, g[1:0], 4'hf});
            reg_rd(ACC_OFS_CFG1, rv);
            check(rv & 8'h3f, {2'b00, g[1:0], 4'hf});
            check({6'h0, ana_o.stage2_gain}, {6'h0, g[1:0]});
        end
        tbl[0] = 8'h00; tbl[1] = 8'h01; tbl[2] = 8'h02; tbl[3] = 8'h03;
        tbl[4] = 8'h04; tbl[5] = 8'h05; tbl[6] = 8'h09; tbl[7] = 8'h0a;
        tbl[8] = 8'h0b; tbl[9] = 8'h0c; tbl[10] = 8'h0d;
        for (int i = 0; i < 11; i++)
        begin
            reg_wr(ACC_OFS_CTRL, {tbl[i][3:0], 4'h0});
            reg_rd(ACC_OFS_CTRL, rv);
            check(rv, {tbl[i][3:0], 4'h0});
            check({4'h0, ana_o.stage2_offset}, tbl[i]);
        end
        // short conversion: osr 8, one elementary conversion
        reg_wr(ACC_OFS_CTRL, 8'h00);
        reg_wr(ACC_OFS_IRQ_MASK, 8'h03);
        reg_wr(ACC_OFS_CFG2, 8'h00);
        reg_wr(ACC_OFS_CTRL, 8'h01);
        reg_rd(ACC_OFS_CTRL, rv);
        check(rv, 8'h00);
        wait_busy(1'b1, 110, cyc);
        check(in_range(cyc, 0, 106), 8'h01);
        check({7'h0, irq_o}, 8'h01);
        reg_rd(ACC_OFS_IRQ_STAT, rv);
        check(rv & 8'h03, 8'h02);
        settle();
        check({7'h0, irq_o}, 8'h00);
        // 9 samples plus 5 tail samples at 100 clocks each
        wait_busy(1'b0, 2000, cyc);
        check(in_range(cyc, 1300, 1510), 8'h01);
        check({7'h0, irq_o}, 8'h01);
        reg_rd(ACC_OFS_IRQ_STAT, rv);
        check(rv & 8'h03, 8'h01);
        // masked run: status sticks, output stays low
        reg_wr(ACC_OFS_IRQ_MASK, 8'h00);
        reg_wr(ACC_OFS_CTRL, 8'h01);
        wait_busy(1'b1, 110, cyc);
        check(in_range(cyc, 0, 106), 8'h01);
        wait_busy(1'b0, 2000, cyc);
        check({7'h0, irq_o}, 8'h00);
        reg_rd(ACC_OFS_IRQ_STAT, rv);
        check(rv & 8'h03, 8'h03);
        reg_rd(ACC_OFS_IRQ_STAT, rv);
        check(rv & 8'h03, 8'h00);
        // long run abandoned by a default load
        reg_wr(ACC_OFS_CFG1, 8'h3f);
        reg_wr(ACC_OFS_CFG2, 8'hff);
        reg_wr(ACC_OFS_CTRL, 8'h01);
        wait_busy(1'b1, 110, cyc);
        reg_wr(ACC_OFS_SEL, 8'h40);
        reg_rd(ACC_OFS_CFG1, rv);
        check(rv & 8'h0f, 8'h00);
        reg_rd(ACC_OFS_CFG2, rv);
        check(rv, 8'h0a);
        reg_rd(ACC_OFS_SEL, rv);
        check(rv & 8'h7f, 8'h00);
        settle();
        check({4'h0, bypass_o}, 8'h0e);
        wait_busy(1'b1, 110, cyc);
        // 2 x 33 samples plus tail, not the 8 x 1025 of the old run
        wait_busy(1'b0, 9000, cyc);
        check(in_range(cyc + 20, 6900, 7420), 8'h01);
        // continuous: sequence restarts after each completion
        reg_wr(ACC_OFS_CFG2, 8'h00);
        reg_wr(ACC_OFS_CTRL, 8'h02);
        reg_rd(ACC_OFS_CTRL, rv);
        check(rv, 8'h02);
        wait_busy(1'b1, 110, cyc);
        check(in_range(cyc, 0, 106), 8'h01);
        wait_busy(1'b0, 2000, cyc);
        wait_busy(1'b1, 110, cyc);
        check(in_range(cyc, 0, 106), 8'h01);
        // clearing continuous lets the running sequence end for good
        reg_wr(ACC_OFS_CTRL, 8'h00);
        wait_busy(1'b0, 2000, cyc);
        wait_busy(1'b1, 300, cyc);
        check(in_range(cyc, 300, 300), 8'h01);
        print_verdict();
    end

endmodule : testbench
